// File: hw/pfsac_consts.svh
// constants for the program flash self-access control block
// assumes a 12-bit special-function register address space on the core
`ifndef PFSAC_CONSTS_SVH
`define PFSAC_CONSTS_SVH
`define PFSAC_ADDR_CTRL     12'hFA6
`define PFSAC_ADDR_UNLOCK   12'hFA7
`define PFSAC_ADDR_LATCH    12'hFF5
`define PFSAC_BIT_PSEL      7
`define PFSAC_BIT_CSEL      6
`define PFSAC_BIT_RSVD      5
`define PFSAC_BIT_ERASE     4
`define PFSAC_BIT_ABORT     3
`define PFSAC_BIT_PERMIT    2
`define PFSAC_BIT_WLAUNCH   1
`define PFSAC_BIT_RLAUNCH   0
`define PFSAC_KEY_FIRST     8'h55
`define PFSAC_KEY_SECOND    8'hAA
`define PFSAC_CTRL_RESET    8'h00
`define PFSAC_NOP_WORD      16'h0000
`define PFSAC_PROG_TIME_US  2000
`define PFSAC_CLK_MHZ       125
`define PFSAC_HOLD_BYTES    8
`endif

// File: hw/pfsac_pkg.sv
// types shared by the flash self-access control block
// assumes nothing beyond a SystemVerilog compiler
package pfsac_pkg;
	typedef enum logic [1:0] {SPACE_EEPROM, SPACE_PROGRAM, SPACE_CONFIG} pfsac_space_e;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} pfsac_sfr_req_s;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [21:0] ptr;
	} pfsac_tbl_req_s;
	typedef struct packed {
		logic         start;
		logic         erase;
		pfsac_space_e space;
		logic [21:0]  addr;
		logic [63:0]  data;
	} pfsac_cmd_s;
endpackage

// File: hw/pfsac_ctrl.sv
// flash self-access control: control register, unlock port, table latch,
// holding registers, programming timer and fetch stall
// assumes core-side inputs are on mclk_in; flash array answers a read one cycle later
`include "pfsac_consts.svh"
module pfsac_ctrl
	import pfsac_pkg::*;
#(
	parameter int PROG_TIME_US = `PFSAC_PROG_TIME_US,
	parameter int PROG_CYCLES  = PROG_TIME_US * `PFSAC_CLK_MHZ
)
(
	input  wire logic           mclk_in,
	input  wire logic           rst_in,
	input  wire logic           abort_rst_in,
	input  wire pfsac_sfr_req_s sfr_req_in,
	output logic [7:0]          sfr_rdata_out,
	input  wire pfsac_tbl_req_s tbl_req_in,
	input  wire logic [15:0]    flash_word_in,
	output logic [20:0]         flash_word_addr_out,
	input  wire logic [15:0]    fetch_word_in,
	input  wire logic           fetch_invalid_in,
	output logic [15:0]         insn_out,
	output logic                stall_out,
	output pfsac_cmd_s          cmd_out,
	output logic                ee_read_out,
	output logic [1:0]          target_out,
	input  wire logic           done_clr_in,
	output logic                nvm_done_flag_out
);
	typedef enum {UNL_IDLE, UNL_GOT55, UNL_ARMED} pfsac_unl_e;
	typedef logic [7:0] pfsac_byte_t;

	// true when the request is a write to the given register
	function automatic logic sfr_hit(input pfsac_sfr_req_s r, input logic [11:0] a);
		sfr_hit = r.wr && (r.addr == a);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]       ctrl_reg, ctrl_next;
	pfsac_byte_t      latch_reg, latch_next;
	pfsac_byte_t      hold_reg [`PFSAC_HOLD_BYTES];
	pfsac_byte_t      hold_next [`PFSAC_HOLD_BYTES];
	pfsac_unl_e       unl_reg, unl_next;
	logic [31:0]      count_reg, count_next;
	logic             busy_reg, busy_next;
	logic             rdpend_reg, rdpend_next;
	logic             rdodd_reg, rdodd_next;
	logic [20:0]      waddr_reg, waddr_next;
	logic [7:0]       rdata_reg, rdata_next;
	logic             done_reg, done_next;
	pfsac_cmd_s       cmd_reg, cmd_next;
	logic             eerd_reg, eerd_next;
	pfsac_space_e     space;
	logic             launch_ok;
	logic             finish;

	// target decode: config select overrides program select
	always_comb
	begin
		if (ctrl_reg[`PFSAC_BIT_CSEL])
			space = SPACE_CONFIG;
		else if (ctrl_reg[`PFSAC_BIT_PSEL])
			space = SPACE_PROGRAM;
		else
			space = SPACE_EEPROM;
	end

	assign finish    = busy_reg && (count_reg == 32'd1);
	// a launch needs permit and the armed unlock state; anything else is dropped silently
	assign launch_ok = sfr_hit(sfr_req_in, `PFSAC_ADDR_CTRL) && sfr_req_in.wdata[`PFSAC_BIT_WLAUNCH]
		&& ctrl_reg[`PFSAC_BIT_PERMIT] && (unl_reg == UNL_ARMED) && !busy_reg;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic for every register of the block
	always_comb
	begin
		ctrl_next   = ctrl_reg;
		latch_next  = latch_reg;
		hold_next   = hold_reg;
		unl_next    = unl_reg;
		count_next  = count_reg;
		busy_next   = busy_reg;
		rdpend_next = 1'b0;
		rdodd_next  = rdodd_reg;
		waddr_next  = waddr_reg;
		rdata_next  = 8'h00;
		done_next   = done_reg | finish;
		cmd_next    = cmd_reg;
		cmd_next.start = 1'b0;
		eerd_next   = 1'b0;
		// read launch lasts one cycle
		ctrl_next[`PFSAC_BIT_RLAUNCH] = 1'b0;
		if (done_clr_in && !finish)
			done_next = 1'b0;
		// register reads; the unlock port and unmapped addresses read zero
		if (sfr_req_in.rd)
		begin
			if (sfr_req_in.addr == `PFSAC_ADDR_CTRL)
				rdata_next = ctrl_reg & ~(8'h01 << `PFSAC_BIT_RSVD);
			else if (sfr_req_in.addr == `PFSAC_ADDR_LATCH)
				rdata_next = latch_reg;
			else
				rdata_next = 8'h00;
		end
		// control writes: launch bits are set-only, abort flag and bit 5 not writable
		if (sfr_hit(sfr_req_in, `PFSAC_ADDR_CTRL))
		begin
			ctrl_next[7:6] = sfr_req_in.wdata[7:6];
			ctrl_next[`PFSAC_BIT_ERASE]  = busy_reg ? ctrl_reg[`PFSAC_BIT_ERASE]
				: sfr_req_in.wdata[`PFSAC_BIT_ERASE];
			ctrl_next[`PFSAC_BIT_PERMIT] = sfr_req_in.wdata[`PFSAC_BIT_PERMIT];
			if (sfr_req_in.wdata[`PFSAC_BIT_RLAUNCH] && !ctrl_reg[`PFSAC_BIT_PSEL] && !busy_reg)
			begin
				ctrl_next[`PFSAC_BIT_RLAUNCH] = 1'b1;
				eerd_next = 1'b1;
			end
			// any control write consumes the unlock pair
			unl_next = UNL_IDLE;
		end
		if (launch_ok)
		begin
			ctrl_next[`PFSAC_BIT_WLAUNCH] = 1'b1;
			busy_next  = 1'b1;
			count_next = PROG_CYCLES;
			cmd_next.start = 1'b1;
			cmd_next.space = space;
			cmd_next.erase = ctrl_reg[`PFSAC_BIT_ERASE] && (space == SPACE_PROGRAM);
			// erase ignores pointer bits 5..0; there is no bulk erase command at all
			if (cmd_next.erase)
				cmd_next.addr = {tbl_req_in.ptr[21:6], 6'h00};
			else
				cmd_next.addr = {tbl_req_in.ptr[21:3], 3'h0};
			for (int i = 0; i < `PFSAC_HOLD_BYTES; i++)
				cmd_next.data[i*8 +: 8] = hold_reg[i];
		end
		// unlock port: no storage, only tracks the key pair
		if (sfr_hit(sfr_req_in, `PFSAC_ADDR_UNLOCK))
		begin
			if (sfr_req_in.wdata == `PFSAC_KEY_FIRST)
				unl_next = UNL_GOT55;
			else if (sfr_req_in.wdata == `PFSAC_KEY_SECOND && unl_reg == UNL_GOT55)
				unl_next = UNL_ARMED;
			else
				unl_next = UNL_IDLE;
		end
		// software write to the latch
		if (sfr_hit(sfr_req_in, `PFSAC_ADDR_LATCH))
			latch_next = sfr_req_in.wdata;
		// table read: fetch word, then latch the addressed byte
		if (tbl_req_in.rd && !busy_reg)
		begin
			rdpend_next = 1'b1;
			waddr_next  = tbl_req_in.ptr[21:1];
			rdodd_next  = tbl_req_in.ptr[0];
		end
		if (rdpend_reg)
			latch_next = rdodd_reg ? flash_word_in[15:8] : flash_word_in[7:0];
		// table write only lands in a holding register
		if (tbl_req_in.wr && !busy_reg)
			hold_next[tbl_req_in.ptr[2:0]] = latch_reg;
		// timer end: clear launch, and erase select after an erase
		if (busy_reg)
		begin
			count_next = count_reg - 32'd1;
			if (finish)
			begin
				busy_next = 1'b0;
				ctrl_next[`PFSAC_BIT_WLAUNCH] = 1'b0;
				if (cmd_reg.erase)
					ctrl_next[`PFSAC_BIT_ERASE] = 1'b0;
				ctrl_next[`PFSAC_BIT_ABORT] = 1'b0;
			end
		end
		// master clear or watchdog reset: selects survive so software can trace the fault
		if (abort_rst_in)
		begin
			ctrl_next[5:0] = 6'h00;
			ctrl_next[`PFSAC_BIT_ABORT] = busy_reg | ctrl_reg[`PFSAC_BIT_ABORT];
			busy_next   = 1'b0;
			count_next  = 32'd0;
			unl_next    = UNL_IDLE;
			latch_next  = 8'h00;
			rdpend_next = 1'b0;
			eerd_next   = 1'b0;
			cmd_next.start = 1'b0;
			for (int i = 0; i < `PFSAC_HOLD_BYTES; i++)
				hold_next[i] = 8'h00;
		end
		ctrl_next[`PFSAC_BIT_RSVD] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers; power-up clears everything including the permit bit
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl_reg   <= `PFSAC_CTRL_RESET;
			latch_reg  <= 8'h00;
			for (int i = 0; i < `PFSAC_HOLD_BYTES; i++)
				hold_reg[i] <= 8'h00;
			unl_reg    <= UNL_IDLE;
			count_reg  <= 32'd0;
			busy_reg   <= 1'b0;
			rdpend_reg <= 1'b0;
			rdodd_reg  <= 1'b0;
			waddr_reg  <= 21'h0;
			rdata_reg  <= 8'h00;
			done_reg   <= 1'b0;
			cmd_reg    <= '0;
			eerd_reg   <= 1'b0;
		end
		else
		begin
			ctrl_reg   <= ctrl_next;
			latch_reg  <= latch_next;
			hold_reg   <= hold_next;
			unl_reg    <= unl_next;
			count_reg  <= count_next;
			busy_reg   <= busy_next;
			rdpend_reg <= rdpend_next;
			rdodd_reg  <= rdodd_next;
			waddr_reg  <= waddr_next;
			rdata_reg  <= rdata_next;
			done_reg   <= done_next;
			cmd_reg    <= cmd_next;
			eerd_reg   <= eerd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; stall is combinational so fetch halts in the successor of a program-space launch cycle
	assign sfr_rdata_out       = rdata_reg;
	assign flash_word_addr_out = waddr_reg;
	assign cmd_out             = cmd_reg;
	assign ee_read_out         = eerd_reg;
	assign target_out          = space;
	assign nvm_done_flag_out   = done_reg;
	assign stall_out           = busy_reg && (cmd_reg.space == SPACE_PROGRAM);
	// invalid words still execute, but as a no-operation
	assign insn_out = fetch_invalid_in ? `PFSAC_NOP_WORD : fetch_word_in;

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [31:0] busy_len;
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			busy_len <= 32'd0;
		else
			busy_len <= busy_reg ? busy_len + 32'd1 : 32'd0;
	end

	// key pair as the core issues it: one idle bus cycle between the two writes
	sequence s_unlock_pair;
		(sfr_hit(sfr_req_in, `PFSAC_ADDR_UNLOCK) && sfr_req_in.wdata == `PFSAC_KEY_FIRST)
		##1 (!sfr_req_in.wr && !abort_rst_in)
		##1 (sfr_hit(sfr_req_in, `PFSAC_ADDR_UNLOCK) && sfr_req_in.wdata == `PFSAC_KEY_SECOND);
	endsequence
	sequence s_launch;
		sfr_hit(sfr_req_in, `PFSAC_ADDR_CTRL) && sfr_req_in.wdata[`PFSAC_BIT_WLAUNCH]
		&& ctrl_reg[`PFSAC_BIT_PERMIT] && !busy_reg && !abort_rst_in;
	endsequence

	AST_UNLOCK_LAUNCH: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_unlock_pair ##1 (!sfr_req_in.wr && !abort_rst_in) ##1 s_launch |=> busy_reg && cmd_reg.start)
		else $error("unlocked launch did not start a cycle");
	AST_NO_PERMIT: assert property (@(posedge mclk_in) disable iff (rst_in)
		!busy_reg && !ctrl_reg[`PFSAC_BIT_PERMIT] |=> !busy_reg)
		else $error("cycle started without write permit");
	AST_STALL: assert property (@(posedge mclk_in) disable iff (rst_in)
		launch_ok && space == SPACE_PROGRAM && !abort_rst_in |=> stall_out)
		else $error("fetch not stalled after flash launch");
	AST_STALL_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
		stall_out && !finish && !abort_rst_in |=> stall_out)
		else $error("fetch stall released before the cycle ended");
	AST_TIMER_END: assert property (@(posedge mclk_in) disable iff (rst_in)
		busy_len <= PROG_CYCLES)
		else $error("cycle outlived the programming timer");
	AST_DONE_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
		finish && !abort_rst_in |=> nvm_done_flag_out && !ctrl_reg[`PFSAC_BIT_WLAUNCH])
		else $error("completion did not set done flag and clear launch");
	AST_ERASE_CLR: assert property (@(posedge mclk_in) disable iff (rst_in)
		finish && cmd_reg.erase && !abort_rst_in |=> !ctrl_reg[`PFSAC_BIT_ERASE])
		else $error("erase select not cleared after erase");
	AST_ABORT: assert property (@(posedge mclk_in) disable iff (rst_in)
		abort_rst_in && busy_reg |=> ctrl_reg[`PFSAC_BIT_ABORT] && !busy_reg)
		else $error("abort not recorded");
	AST_ABORT_SEL: assert property (@(posedge mclk_in) disable iff (rst_in)
		abort_rst_in |=> ctrl_reg[7:6] == $past(ctrl_reg[7:6]))
		else $error("select bits changed by abort");
	AST_RD_ONE: assert property (@(posedge mclk_in) disable iff (rst_in)
		ctrl_reg[`PFSAC_BIT_RLAUNCH] |=> !ctrl_reg[`PFSAC_BIT_RLAUNCH] ##0 !ee_read_out)
		else $error("read launch lasted more than one cycle");
	AST_RD_BLOCK: assert property (@(posedge mclk_in) disable iff (rst_in)
		sfr_hit(sfr_req_in, `PFSAC_ADDR_CTRL) && sfr_req_in.wdata[`PFSAC_BIT_RLAUNCH]
		&& ctrl_reg[`PFSAC_BIT_PSEL] |=> !ee_read_out)
		else $error("read launched with program select set");
	AST_BIT5: assert property (@(posedge mclk_in) disable iff (rst_in)
		sfr_req_in.rd && sfr_req_in.addr == `PFSAC_ADDR_CTRL |=> !sfr_rdata_out[`PFSAC_BIT_RSVD])
		else $error("reserved control bit read as one");
	AST_UNLOCK_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
		sfr_req_in.rd && sfr_req_in.addr == `PFSAC_ADDR_UNLOCK |=> sfr_rdata_out == 8'h00)
		else $error("unlock port read nonzero");
endmodule

// File: test/pfsac_flash_model.sv
// flash array stand-in that answers table-read word fetches
// assumes the word is sampled while the registered word address stands
module pfsac_flash_model
(
	input  wire logic [20:0] word_addr_in,
	output logic [15:0]      word_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// pattern from the address, high and low bytes differ so a byte-lane swap shows
	assign word_out = {word_addr_in[7:0] ^ 8'h5A, word_addr_in[7:0]};
endmodule

// File: test/tb_top.sv
// self-checking bench for the flash self-access control block
// assumes hw/pfsac_pkg.sv and hw/pfsac_ctrl.sv compiled first; inputs move at falling edges
`include "pfsac_consts.svh"
module tb_top;
	import pfsac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic           mclk = 1'b0;
	logic           rst = 1'b1;
	logic           abort_rst = 1'b0;
	pfsac_sfr_req_s sfr = '0;
	pfsac_tbl_req_s tbl = '0;
	logic [7:0]     rdata;
	logic [15:0]    fword;
	logic [20:0]    faddr;
	logic [15:0]    fetch_word = 16'hBEEF;
	logic           fetch_bad = 1'b0;
	logic [15:0]    insn;
	logic           stall;
	pfsac_cmd_s     cmd;
	pfsac_cmd_s     cap;
	logic           ee_rd;
	logic [1:0]     target;
	logic           done_clr = 1'b0;
	logic           done;
	logic [7:0]     d;
	logic [63:0]    exp_data;
	int             errors = 0;
	int             n_tests = 0;
	int             n_starts = 0;
	int             n_eerd = 0;
	// short programming time keeps the run brief
	pfsac_ctrl #(.PROG_CYCLES(20)) u_pfsac_ctrl (.mclk_in(mclk), .rst_in(rst), .abort_rst_in(abort_rst),
		.sfr_req_in(sfr), .sfr_rdata_out(rdata), .tbl_req_in(tbl), .flash_word_in(fword),
		.flash_word_addr_out(faddr), .fetch_word_in(fetch_word), .fetch_invalid_in(fetch_bad),
		.insn_out(insn), .stall_out(stall), .cmd_out(cmd), .ee_read_out(ee_rd), .target_out(target),
		.done_clr_in(done_clr), .nvm_done_flag_out(done));
	pfsac_flash_model u_pfsac_flash_model (.word_addr_in(faddr), .word_out(fword));
	// 125 MHz clock
	always #4 mclk = ~mclk;
	// count launch pulses and eeprom read pulses at the sampling edge
	always @(posedge mclk)
	begin
		if (cmd.start === 1'b1)
			cap <= cmd;
		n_starts <= n_starts + int'(cmd.start === 1'b1);
		n_eerd <= n_eerd + int'(ee_rd === 1'b1);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic sfr_wr(input logic [11:0] a, input logic [7:0] v);
		@(negedge mclk);
		sfr = '{1'b1, 1'b0, a, v};
		@(negedge mclk);
		sfr.wr = 1'b0;
	endtask
	task automatic sfr_rd(input logic [11:0] a, output logic [7:0] v);
		@(negedge mclk);
		sfr = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk);
		sfr.rd = 1'b0;
		v = rdata;
	endtask
	task automatic tbl_op(input logic r, input logic w, input logic [21:0] p);
		@(negedge mclk);
		tbl = '{r, w, p};
		@(negedge mclk);
		tbl.rd = 1'b0;
		tbl.wr = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	// software side: arm with the key pair right before the launch write
	task automatic launch(input logic [7:0] v);
		sfr_wr(`PFSAC_ADDR_CTRL, v);
		sfr_wr(`PFSAC_ADDR_UNLOCK, `PFSAC_KEY_FIRST);
		sfr_wr(`PFSAC_ADDR_UNLOCK, `PFSAC_KEY_SECOND);
		sfr_wr(`PFSAC_ADDR_CTRL, v | 8'h02);
		repeat (2) @(negedge mclk);
	endtask
	task automatic finish_cycle(input logic [7:0] ctrl_exp);
		for (int i = 0; i < 200 && done !== 1'b1; i++)
			@(negedge mclk);
		check("done_flag", done, 1'b1);
		check("stall_end", stall, 1'b0);
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("ctrl_end", d, ctrl_exp);
		done_clr = 1'b1;
		@(negedge mclk);
		done_clr = 1'b0;
		@(negedge mclk);
		check("done_clear", done, 1'b0);
	endtask
	function automatic logic [7:0] exp_byte(input logic [21:0] p);
		return p[0] ? (p[8:1] ^ 8'h5A) : p[8:1];
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_bits();
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("ctrl_reset", d, 8'h00);
		sfr_rd(`PFSAC_ADDR_UNLOCK, d);
		check("unlock_read", d, 8'h00);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'hFF);
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("ctrl_ff", d, 8'hD4);
		check("target_cfg", target, 2'd2);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'h80);
		check("target_prog", target, 2'd1);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'h01);
		repeat (2) @(negedge mclk);
		check("ee_reads", n_eerd, 1);
		check("target_ee", target, 2'd0);
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("rd_selfclear", d, 8'h00);
		$display("test bits done");
	endtask
	task automatic t_program();
		tbl_op(1'b1, 1'b0, 22'h012345);
		check("word_addr", faddr, 21'h0091A2);
		sfr_rd(`PFSAC_ADDR_LATCH, d);
		check("latch_odd", d, exp_byte(22'h012345));
		for (int i = 0; i < 8; i++)
		begin
			sfr_wr(`PFSAC_ADDR_LATCH, 8'hC0 + 8'(i));
			exp_data[8*i +: 8] = 8'hC0 + 8'(i);
			tbl_op(1'b0, 1'b1, 22'h0ABCD8 + 22'(i));
		end
		check("no_early_write", n_starts, 0);
		tbl.ptr = 22'h0ABCDB;
		launch(8'h84);
		check("starts", n_starts, 1);
		check("cmd_addr", cap.addr, 22'h0ABCD8);
		check("cmd_data", cap.data, exp_data);
		check("cmd_erase", cap.erase, 1'b0);
		check("cmd_space", cap.space, SPACE_PROGRAM);
		check("stall", stall, 1'b1);
		fetch_bad = 1'b1;
		#1 check("insn_nop", insn, 16'h0000);
		fetch_bad = 1'b0;
		#1 check("insn_pass", insn, 16'hBEEF);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'h84);
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("wr_held", d, 8'h86);
		finish_cycle(8'h84);
		$display("test program done");
	endtask
	task automatic t_erase();
		tbl.ptr = 22'h2ABCFF;
		launch(8'h94);
		check("erase_addr", cap.addr, 22'h2ABCC0);
		check("erase_flag", cap.erase, 1'b1);
		finish_cycle(8'h84);
		$display("test erase done");
	endtask
	task automatic t_refuse();
		launch(8'h80);
		check("no_permit", n_starts, 2);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'h84);
		sfr_wr(`PFSAC_ADDR_UNLOCK, `PFSAC_KEY_FIRST);
		sfr_wr(`PFSAC_ADDR_UNLOCK, 8'h12);
		sfr_wr(`PFSAC_ADDR_UNLOCK, `PFSAC_KEY_SECOND);
		sfr_wr(`PFSAC_ADDR_CTRL, 8'h86);
		repeat (2) @(negedge mclk);
		check("bad_key", n_starts, 2);
		$display("test refuse done");
	endtask
	task automatic t_abort();
		launch(8'h84);
		repeat (4) @(negedge mclk);
		abort_rst = 1'b1;
		@(negedge mclk);
		abort_rst = 1'b0;
		sfr_rd(`PFSAC_ADDR_CTRL, d);
		check("abort_ctrl", d, 8'h88);
		check("abort_stall", stall, 1'b0);
		check("abort_done", done, 1'b0);
		// abort zeroed the latch and holding registers but not the pointer, which is set to a new address before the retry
		tbl.ptr = 22'h0ABCD8;
		launch(8'hC4);
		check("cfg_space", cap.space, SPACE_CONFIG);
		check("cfg_nostall", stall, 1'b0);
		finish_cycle(8'hC4);
		$display("test abort done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog sized well above the few hundred cycles the tests need
	initial
	begin
		#200000;
		errors++;
		end_of_test();
	end
	// reset for 16 cycles, then run every scenario
	initial
	begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_bits();
		t_program();
		t_erase();
		t_refuse();
		t_abort();
		end_of_test();
	end
endmodule
